// *** design/nts_device.sv ***
// Module end: local time base, offset store, input/measure stamping, scheduled output
`timescale 1ns/1ps
module nts_device
(
  input wire logic clk,
  input wire logic rst_n,
  nts_link_if.dev link,
  input wire logic in_pin,
  input wire logic meas_start,
  input wire logic meas_end,
  input wire logic sched_load,
  input wire logic sched_level,
  input wire nts_pkg::nts_time_t sched_time,
  output logic synced,
  output nts_pkg::nts_time_t rise_time,
  output logic rise_valid,
  output nts_pkg::nts_time_t fall_time,
  output logic fall_valid,
  output nts_pkg::nts_time_t meas_start_time,
  output nts_pkg::nts_time_t meas_end_time,
  output logic meas_valid,
  output logic out_pin,
  output logic sched_pending
);
  import nts_pkg::*;

  // ----------------------------------------
  // Microsecond tick and local counter
  // ----------------------------------------
  logic [7:0] pre;
  logic [7:0] next_pre;
  nts_time_t local_time;
  nts_time_t next_local_time;
  logic us_tick;

  // Prescale must fit the 8-bit divider; refused at elaboration
  if (NTS_US_CYCLES < 1 || NTS_US_CYCLES > 255)
  begin : g_prescale_check
    $error("prescale out of range");
  end

  // Free-running local base; unsynchronised to the master by design
  always_comb
  begin
    us_tick = (pre == 8'(NTS_US_CYCLES - 1));
    next_pre = us_tick ? 8'h00 : pre + 8'h01;
    next_local_time = us_tick ? local_time + 32'h0000_0001 : local_time;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pre <= 8'h00;
      local_time <= NTS_TIME_RESET;
    end
    else
    begin
      pre <= next_pre;
      local_time <= next_local_time;
    end
  end

  // ----------------------------------------
  // Offset store and corrected time
  // ----------------------------------------
  nts_time_t offset;
  nts_time_t next_offset;
  logic next_synced;
  nts_time_t now_sys;

  // Offset refreshed each cycle start; startup forces a fresh alignment
  always_comb
  begin
    next_offset = offset;
    next_synced = synced;
    if (link.startup || link.cycle_start)
    begin
      next_offset = link.sys_time - local_time;
      next_synced = 1'b1;
    end
    now_sys = local_time + offset;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      offset <= NTS_TIME_RESET;
      synced <= 1'b0;
    end
    else
    begin
      offset <= next_offset;
      synced <= next_synced;
    end
  end

  // ----------------------------------------
  // Input edge and measurement stamps
  // ----------------------------------------
  logic in_q;
  logic next_in_q;
  nts_time_t next_rise_time;
  nts_time_t next_fall_time;
  nts_time_t next_ms_time;
  nts_time_t next_me_time;
  logic next_rise_valid;
  logic next_fall_valid;
  logic next_meas_valid;

  // Stamps are taken in the edge cycle, so they always lie in the past
  always_comb
  begin
    next_in_q = in_pin;
    next_rise_time = rise_time;
    next_fall_time = fall_time;
    next_ms_time = meas_start_time;
    next_me_time = meas_end_time;
    next_rise_valid = 1'b0;
    next_fall_valid = 1'b0;
    next_meas_valid = 1'b0;
    if (in_pin && !in_q)
    begin
      next_rise_time = now_sys;
      next_rise_valid = 1'b1;
    end
    if (!in_pin && in_q)
    begin
      next_fall_time = now_sys;
      next_fall_valid = 1'b1;
    end
    if (meas_start)
      next_ms_time = now_sys;
    if (meas_end)
    begin
      next_me_time = now_sys;
      next_meas_valid = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      in_q <= 1'b0;
      rise_time <= NTS_TIME_RESET;
      fall_time <= NTS_TIME_RESET;
      meas_start_time <= NTS_TIME_RESET;
      meas_end_time <= NTS_TIME_RESET;
      rise_valid <= 1'b0;
      fall_valid <= 1'b0;
      meas_valid <= 1'b0;
    end
    else
    begin
      in_q <= next_in_q;
      rise_time <= next_rise_time;
      fall_time <= next_fall_time;
      meas_start_time <= next_ms_time;
      meas_end_time <= next_me_time;
      rise_valid <= next_rise_valid;
      fall_valid <= next_fall_valid;
      meas_valid <= next_meas_valid;
    end
  end

  // ----------------------------------------
  // Scheduled output edge
  // ----------------------------------------
  nts_time_t sched_at;
  nts_time_t next_sched_at;
  logic sched_lvl;
  logic next_sched_lvl;
  logic next_sched_pending;
  logic next_out_pin;

  // One pending edge; a new load replaces it. Past times fire at once.
  always_comb
  begin
    next_sched_at = sched_at;
    next_sched_lvl = sched_lvl;
    next_sched_pending = sched_pending;
    next_out_pin = out_pin;
    if (sched_pending && !nts_before(now_sys, sched_at))
    begin
      next_out_pin = sched_lvl;
      next_sched_pending = 1'b0;
    end
    if (sched_load)
    begin
      next_sched_at = sched_time;
      next_sched_lvl = sched_level;
      next_sched_pending = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sched_at <= NTS_TIME_RESET;
      sched_lvl <= 1'b0;
      sched_pending <= 1'b0;
      out_pin <= 1'b0;
    end
    else
    begin
      sched_at <= next_sched_at;
      sched_lvl <= next_sched_lvl;
      sched_pending <= next_sched_pending;
      out_pin <= next_out_pin;
    end
  end

endmodule : nts_device

// *** inc/nts_pkg.sv ***
// Package of constants and types shared by both ends of the timestamp sync link
package nts_pkg;

  // ----------------------------------------
  // Time base
  // ----------------------------------------
  localparam int NTS_TIME_W = 32;
  localparam int unsigned NTS_CLK_MHZ = 100;
  localparam int unsigned NTS_US_NS = 1000;
  localparam int unsigned NTS_CLK_NS = 10;
  localparam int unsigned NTS_US_CYCLES = NTS_US_NS / NTS_CLK_NS;
  localparam logic [31:0] NTS_TIME_RESET = 32'h0000_0000;

  // ----------------------------------------
  // Partner timing
  // ----------------------------------------
  localparam logic [31:0] NTS_SOC_OFFSET_US = 32'h0000_0014;
  localparam logic [31:0] NTS_LINK_CYCLE_US = 32'h0000_03E8;

  typedef logic [NTS_TIME_W-1:0] nts_time_t;

  // Wrap-safe "a is before b" using signed difference
  function automatic logic nts_before(input nts_time_t a, input nts_time_t b);
    nts_time_t d;
    d = a - b;
    return d[NTS_TIME_W-1];
  endfunction : nts_before

endpackage : nts_pkg

// *** inc/nts_link_if.sv ***
// Interface joining the controller end and the module end
`timescale 1ns/1ps
interface nts_link_if;
  import nts_pkg::*;
  logic cycle_start;
  nts_time_t sys_time;
  logic startup;

  modport ctrl
  (
    output cycle_start,
    output sys_time,
    output startup
  );
  modport dev
  (
    input cycle_start,
    input sys_time,
    input startup
  );
endinterface : nts_link_if

// *** design/nts_ctrl.sv ***
// Controller end: system time base and per-cycle time distribution
`timescale 1ns/1ps
module nts_ctrl
(
  input wire logic clk,
  input wire logic rst_n,
  nts_link_if.ctrl link,
  input wire logic start_req,
  output nts_pkg::nts_time_t sys_time,
  output nts_pkg::nts_time_t link_ref_time,
  output nts_pkg::nts_time_t net_ref_time
);
  import nts_pkg::*;

  // ----------------------------------------
  // System time and link cycle timer
  // ----------------------------------------
  logic [7:0] pre;
  logic [7:0] next_pre;
  nts_time_t next_sys_time;
  nts_time_t cyc_us;
  nts_time_t next_cyc_us;
  logic us_tick;
  logic cyc_end;
  logic next_cycle_start;
  logic next_startup;
  logic cycle_start_q;
  logic startup_q;
  nts_time_t sys_latch;
  nts_time_t next_sys_latch;
  nts_time_t next_link_ref;
  nts_time_t next_net_ref;

  // Time is latched at each cycle end or start request so the link sees a stable word
  always_comb
  begin
    us_tick = (pre == 8'(NTS_US_CYCLES - 1));
    next_pre = us_tick ? 8'h00 : pre + 8'h01;
    next_sys_time = us_tick ? sys_time + 32'h0000_0001 : sys_time;
    cyc_end = us_tick && (cyc_us == NTS_LINK_CYCLE_US - 32'h0000_0001);
    next_cyc_us = us_tick ? (cyc_end ? 32'h0000_0000 : cyc_us + 32'h0000_0001) : cyc_us;
    next_cycle_start = cyc_end;
    next_startup = start_req;
    next_sys_latch = (cyc_end || start_req) ? next_sys_time : sys_latch;
    // Midpoint reference lags by half a cycle
    next_link_ref = next_sys_time - (NTS_LINK_CYCLE_US >> 1);
    next_net_ref = next_sys_time - NTS_LINK_CYCLE_US + NTS_SOC_OFFSET_US;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pre <= 8'h00;
      sys_time <= NTS_TIME_RESET;
      cyc_us <= NTS_TIME_RESET;
      cycle_start_q <= 1'b0;
      startup_q <= 1'b0;
      sys_latch <= NTS_TIME_RESET;
      link_ref_time <= NTS_TIME_RESET;
      net_ref_time <= NTS_TIME_RESET;
    end
    else
    begin
      pre <= next_pre;
      sys_time <= next_sys_time;
      cyc_us <= next_cyc_us;
      cycle_start_q <= next_cycle_start;
      startup_q <= next_startup;
      sys_latch <= next_sys_latch;
      link_ref_time <= next_link_ref;
      net_ref_time <= next_net_ref;
    end
  end

  assign link.cycle_start = cycle_start_q;
  assign link.startup = startup_q;
  assign link.sys_time = sys_latch;

endmodule : nts_ctrl

// *** tb/nts_properties.sv ***
// Link-side property checker for the timestamp sync pair
`timescale 1ns/1ps
module nts_properties
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cycle_start,
  input wire logic startup,
  input wire nts_pkg::nts_time_t sys_time
);
  import nts_pkg::*;
  // ----
  // Link timing
  // ----
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_CS_PULSE: assert property (cycle_start |=> !cycle_start [*8])
    else $error("cycle start longer than one pulse");
  AST_SU_PULSE: assert property (startup |=> !startup)
    else $error("startup longer than one cycle");
  // The latch and its pulse leave the same flop edge, so they appear together
  AST_LATCH_LEAD: assert property ($changed(sys_time) |-> (cycle_start || startup))
    else $error("latched time without a pulse");
  AST_PULSE_STABLE: assert property ((cycle_start || startup) |=> $stable(sys_time))
    else $error("time moved under a pulse");
  AST_LATCH_HOLD: assert property ($changed(sys_time) |=> $stable(sys_time) [*3])
    else $error("latched time not held");
  AST_FORWARD: assert property ($changed(sys_time) |-> !nts_before(sys_time, $past(sys_time)))
    else $error("latched time went backwards");
  // Main scenarios reached
  cover property (startup);
  cover property (cycle_start);
  cover property ($changed(sys_time));
endmodule : nts_properties

// *** tb/tb_network_timestamp_sync.sv ***
// Testbench joining controller and module ends
`timescale 1ns/1ps
module tb_network_timestamp_sync;
  import nts_pkg::*;
  logic clk, rst_n, dev_rst_n, start_req, in_pin, meas_start, meas_end, sched_load, sched_level;
  logic synced, rise_valid, fall_valid, meas_valid, out_pin, sched_pending;
  nts_time_t sched_time, rise_time, fall_time, m_st, m_en, st, lr, nr;
  int fails, n_checks, seed, k;
  nts_time_t q[$];
  nts_link_if nts_link_if_inst();
  nts_ctrl nts_ctrl_inst (.clk(clk), .rst_n(rst_n), .link(nts_link_if_inst), .start_req(start_req),
    .sys_time(st), .link_ref_time(lr), .net_ref_time(nr));
  nts_device nts_device_inst (.clk(clk), .rst_n(dev_rst_n), .link(nts_link_if_inst), .in_pin(in_pin),
    .meas_start(meas_start), .meas_end(meas_end), .sched_load(sched_load), .sched_level(sched_level),
    .sched_time(sched_time), .synced(synced), .rise_time(rise_time), .rise_valid(rise_valid),
    .fall_time(fall_time), .fall_valid(fall_valid), .meas_start_time(m_st), .meas_end_time(m_en),
    .meas_valid(meas_valid), .out_pin(out_pin), .sched_pending(sched_pending));
  nts_properties nts_properties_inst (.clk(clk), .rst_n(rst_n), .cycle_start(nts_link_if_inst.cycle_start),
    .startup(nts_link_if_inst.startup), .sys_time(nts_link_if_inst.sys_time));
  // ----
  // Helpers
  // ----
  task automatic check(input nts_time_t seen, input nts_time_t exp);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask : pulse
  task automatic sched(input nts_time_t t, input logic l);
    sched_time = t;
    sched_level = l;
    pulse(sched_load);
  endtask : sched
  // Free-running 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Rise stamps against system time; spans cancel the offset
  always @(negedge clk)
    if (rise_valid === 1'b1)
      check(rise_time, q.pop_front());
    else if (fall_valid === 1'b1)
      check(fall_time - rise_time, q.pop_front());
    else if (meas_valid === 1'b1)
      check(m_en - m_st, q.pop_front());
  // Hang guard, a little beyond the planned run
  initial
  begin
    #1200000;
    fails++;
    summarize();
  end
  // ----
  // Main sequence
  // ----
  initial
  begin
    seed = 32;
    {rst_n, start_req, in_pin, meas_start, meas_end, sched_load, sched_level} = 7'h00;
    sched_time = 32'h0;
    dev_rst_n = 1'b0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    // Module starts whole microseconds late, so its own count trails system time
    k = 1 + ($random(seed) & 3);
    repeat (k * 100) @(negedge clk);
    dev_rst_n = 1'b1;
    repeat (20) @(negedge clk);
    check({31'h0, synced}, 32'h0);
    $display("reset done");
    pulse(start_req);
    repeat (4) @(negedge clk);
    check({31'h0, synced}, 32'h1);
    $display("startup done");
    for (int i = 0; i < 4; i++)
    begin
      k = 1 + ($random(seed) & 7);
      // System time before the capture edge is the corrected stamp
      q.push_back(st);
      q.push_back(nts_time_t'(k));
      in_pin = 1'b1;
      repeat (k * 100) @(negedge clk);
      in_pin = 1'b0;
      repeat (150) @(negedge clk);
    end
    $display("edge stamps done");
    q.push_back(32'h3);
    pulse(meas_start);
    repeat (299) @(negedge clk);
    pulse(meas_end);
    repeat (20) @(negedge clk);
    $display("measurement done");
    // Base the target on a fresh stamp, 5 us ahead
    q.push_back(st);
    q.push_back(32'h8);
    in_pin = 1'b1;
    repeat (3) @(negedge clk);
    sched(rise_time + 32'h5, 1'b1);
    check({31'h0, sched_pending}, 32'h1);
    repeat (396) @(negedge clk);
    check({31'h0, out_pin}, 32'h0);
    repeat (400) @(negedge clk);
    in_pin = 1'b0;
    check({30'h0, out_pin, sched_pending}, 32'h2);
    // Deliberately late target: the module fires it at once
    sched(rise_time - 32'hA, 1'b0);
    repeat (2) @(negedge clk);
    check({31'h0, out_pin}, 32'h0);
    check(st - lr, 32'h1F4);
    check(st - nr, 32'h3D4);
    $display("schedule done");
    // Mid-run module reset: with no new start request, only a cycle start realigns it now
    dev_rst_n = 1'b0;
    repeat (6) @(negedge clk);
    dev_rst_n = 1'b1;
    @(negedge clk);
    check({31'h0, synced}, 32'h0);
    k = 0;
    while (nts_link_if_inst.cycle_start !== 1'b1 && k < 100000)
    begin
      @(negedge clk);
      k++;
    end
    repeat (2) @(negedge clk);
    check({30'h0, nts_link_if_inst.cycle_start, synced}, 32'h1);
    $display("link cycle done");
    summarize();
  end
endmodule : tb_network_timestamp_sync
